// ### cod_map.vh
// Constants for the CPU operand decoder: the addition opcode, field kinds, widths, states and reset values.
`ifndef COD_MAP_VH
`define COD_MAP_VH

// Opcode of the two-register addition form (opcode, source byte, destination byte).
`define COD_OPC_ADD_RR      8'h04

// Upper nibble that marks an 8-bit register field as an escaped working register.
`define COD_ESC_NIBBLE      4'he

// Field widths.
`define COD_REG_ADDR_W      12
`define COD_WORD_W          16
`define COD_BIT_IDX_W       3
`define COD_WREG_IDX_W      4

// Operand field kinds presented on fieldKind.
`define COD_KIND_BIT        4'h0
`define COD_KIND_POL        4'h1
`define COD_KIND_DIRECT     4'h2
`define COD_KIND_EXT_REG    4'h3
`define COD_KIND_IMM        4'h4
`define COD_KIND_REG        4'h5
`define COD_KIND_WREG       4'h6
`define COD_KIND_WREG_IND   4'h7
`define COD_KIND_REG_IND    4'h8
`define COD_KIND_WPAIR      4'h9
`define COD_KIND_WPAIR_IND  4'ha
`define COD_KIND_RPAIR      4'hb
`define COD_KIND_RPAIR_IND  4'hc
`define COD_KIND_REL        4'hd
`define COD_KIND_INDEXED    4'he
`define COD_KIND_VECTOR     4'hf

// One-hot states of the addition sequencer.
`define COD_ST_IDLE         5'h01
`define COD_ST_SRC          5'h02
`define COD_ST_DST          5'h04
`define COD_ST_READ         5'h08
`define COD_ST_EXEC         5'h10

// Reset values of the decoded outputs.
`define COD_RST_BYTE        8'h00
`define COD_RST_ADDR        12'h000
`define COD_RST_WORD        16'h0000

`endif

// ### cod_reg_resolve.v
// Resolves an 8-bit register field into a 12-bit register-file address.
`timescale 1ns/100ps
`include "cod_map.vh"

module cod_reg_resolve (
    input  wire [7:0]  regField,
    input  wire [7:0]  workingBankPointer,
    output wire [11:0] regAddr,
    output wire        escaped
);

    // An upper nibble of E selects a working register; anything else is an absolute location.
    assign escaped = (regField[7:4] == `COD_ESC_NIBBLE);

    // Working registers sit in the group named by the pointer, whose low nibble picks the page.
    // Absolute locations stay in the first 256 bytes, so E0..EF cannot be reached directly.
    assign regAddr = escaped ? {workingBankPointer[3:0], workingBankPointer[7:4], regField[3:0]}
                             : {4'h0, regField};

endmodule

// ### cod_operand_decoder.v
// Operand decoder: two-register addition sequencer and addressing-mode field decoder.
`timescale 1ns/100ps
`include "cod_map.vh"

// Behaviour
// - Addition object code: opcode, source, destination.
// - Register field: absolute 0-255 or escaped working.
// - Field E8 means working register eight.
// - Bit index is three bits, zero to seven.
// - Polarity is one bit, zero or one.
// - Direct address is full sixteen bits.
// - Extended register address is twelve bits.
// - Working pairs use even indices zero to fourteen.
// - Register pairs use even addresses up to FE.
// - Relative displacement added to next instruction address.
// - Indexed address is base plus signed index.
// - Immediate operand is one literal data byte.
// - Trap vector is an eight-bit value.
// - Indirect working register contents give operand address.
// - Addition writes source plus destination into destination.

module cod_operand_decoder (
    input  wire        clk,
    input  wire        rstn,
    // Instruction byte stream from the fetch unit.
    input  wire        byteValid,
    input  wire        instrStart,
    input  wire [7:0]  byteData,
    input  wire [7:0]  workingBankPointer,
    // Register file read port answer for the addition.
    input  wire [7:0]  rdSrcData,
    input  wire [7:0]  rdDstData,
    // Addition sequencer outputs.
    output reg         addBusy_q,
    output reg         rdEn_q,
    output reg  [11:0] rdSrcAddr_q,
    output reg  [11:0] rdDstAddr_q,
    output reg         srcEscaped_q,
    output reg         dstEscaped_q,
    output reg         wrEn_q,
    output reg  [11:0] wrAddr_q,
    output reg  [7:0]  wrData_q,
    // Generic operand field decode request.
    input  wire        fieldReq,
    input  wire [3:0]  fieldKind,
    input  wire [15:0] fieldWord,
    input  wire [15:0] fieldBase,
    // Generic operand field decode answer.
    output reg         fieldDone_q,
    output reg  [15:0] fieldAddr_q,
    output reg  [11:0] fieldRegAddr_q,
    output reg  [7:0]  fieldData_q,
    output reg  [2:0]  fieldBit_q,
    output reg         fieldPol_q,
    output reg         fieldEscaped_q,
    output reg         fieldIllegal_q
);

    localparam [4:0] S_IDLE = `COD_ST_IDLE;
    localparam [4:0] S_SRC  = `COD_ST_SRC;
    localparam [4:0] S_DST  = `COD_ST_DST;
    localparam [4:0] S_READ = `COD_ST_READ;
    localparam [4:0] S_EXEC = `COD_ST_EXEC;

    reg  [4:0]  state_q;
    reg  [4:0]  state_d;
    reg  [7:0]  srcField_q;
    wire [11:0] srcAddr;
    wire [11:0] dstAddr;
    wire [11:0] fldRegAddr;
    wire        srcEsc;
    wire        dstEsc;
    wire        fldEsc;
    wire        opcStart;

    // Sign-extends an 8-bit displacement to a full address word.
    function [15:0] signExt8;
        input [7:0] disp;
        begin
            signExt8 = {{8{disp[7]}}, disp};
        end
    endfunction

    // Working register address for a 4-bit index, offset by the bank pointer.
    function [11:0] wregAddr;
        input [3:0] idx;
        input [7:0] ptr;
        begin
            wregAddr = {ptr[3:0], ptr[7:4], idx};
        end
    endfunction

    // The source field was captured one byte earlier; the destination is resolved as it arrives.
    cod_reg_resolve uSrcResolve (
        .regField           (srcField_q),
        .workingBankPointer (workingBankPointer),
        .regAddr            (srcAddr),
        .escaped            (srcEsc)
    );

    cod_reg_resolve uDstResolve (
        .regField           (byteData),
        .workingBankPointer (workingBankPointer),
        .regAddr            (dstAddr),
        .escaped            (dstEsc)
    );

    cod_reg_resolve uFieldResolve (
        .regField           (fieldWord[7:0]),
        .workingBankPointer (workingBankPointer),
        .regAddr            (fldRegAddr),
        .escaped            (fldEsc)
    );

    // An addition begins only on an opcode byte equal to the addition opcode.
    assign opcStart = byteValid & instrStart & (byteData == `COD_OPC_ADD_RR);

    // Next-state logic of the addition sequencer.
    // A fresh opcode during operand collection aborts the sequence and restarts it only
    // for the addition opcode, so a flushed fetch never leaves a half-built addition behind.
    always @* begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (opcStart) begin
                    state_d = S_SRC;
                end
            end
            S_SRC: begin
                if (byteValid && instrStart) begin
                    state_d = opcStart ? S_SRC : S_IDLE;
                end else if (byteValid) begin
                    state_d = S_DST;
                end
            end
            S_DST: begin
                if (byteValid && instrStart) begin
                    state_d = opcStart ? S_SRC : S_IDLE;
                end else if (byteValid) begin
                    state_d = S_READ;
                end
            end
            S_READ: begin
                state_d = S_EXEC;
            end
            S_EXEC: begin
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // State register and busy flag.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= S_IDLE;
            addBusy_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            addBusy_q <= (state_d != S_IDLE);
        end
    end

    // Operand capture and register file read request.
    // Bytes that arrive during the read and execute cycles are ignored; the
    // fetch unit watches addBusy_q to avoid that.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            srcField_q   <= `COD_RST_BYTE;
            rdEn_q       <= 1'b0;
            rdSrcAddr_q  <= `COD_RST_ADDR;
            rdDstAddr_q  <= `COD_RST_ADDR;
            srcEscaped_q <= 1'b0;
            dstEscaped_q <= 1'b0;
        end else begin
            rdEn_q <= 1'b0;
            if (state_q == S_SRC && byteValid && !instrStart) begin
                srcField_q <= byteData;
            end
            if (state_q == S_DST && byteValid && !instrStart) begin
                rdEn_q       <= 1'b1;
                rdSrcAddr_q  <= srcAddr;
                rdDstAddr_q  <= dstAddr;
                srcEscaped_q <= srcEsc;
                dstEscaped_q <= dstEsc;
            end
        end
    end

    // Execute: the sum wraps in eight bits and replaces the destination.
    // Carry and flags belong to the ALU downstream, not to this decoder.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrEn_q   <= 1'b0;
            wrAddr_q <= `COD_RST_ADDR;
            wrData_q <= `COD_RST_BYTE;
        end else begin
            wrEn_q <= 1'b0;
            if (state_q == S_EXEC) begin
                wrEn_q   <= 1'b1;
                wrAddr_q <= rdDstAddr_q;
                wrData_q <= rdDstData + rdSrcData;
            end
        end
    end

    // Generic field decode: one request per cycle, answered at the next edge.
    // Outputs not meaningful for a kind keep their earlier value, except fieldEscaped_q and fieldIllegal_q, which clear.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fieldDone_q    <= 1'b0;
            fieldAddr_q    <= `COD_RST_WORD;
            fieldRegAddr_q <= `COD_RST_ADDR;
            fieldData_q    <= `COD_RST_BYTE;
            fieldBit_q     <= 3'h0;
            fieldPol_q     <= 1'b0;
            fieldEscaped_q <= 1'b0;
            fieldIllegal_q <= 1'b0;
        end else begin
            fieldDone_q <= fieldReq;
            if (fieldReq) begin
                fieldEscaped_q <= 1'b0;
                fieldIllegal_q <= 1'b0;
                case (fieldKind)
                    `COD_KIND_BIT: begin
                        fieldBit_q <= fieldWord[2:0];
                    end
                    `COD_KIND_POL: begin
                        fieldPol_q <= fieldWord[0];
                    end
                    `COD_KIND_DIRECT: begin
                        fieldAddr_q <= fieldWord;
                    end
                    `COD_KIND_EXT_REG: begin
                        fieldRegAddr_q <= fieldWord[11:0];
                    end
                    `COD_KIND_IMM: begin
                        fieldData_q <= fieldWord[7:0];
                    end
                    `COD_KIND_REG: begin
                        fieldRegAddr_q <= fldRegAddr;
                        fieldEscaped_q <= fldEsc;
                    end
                    `COD_KIND_WREG: begin
                        fieldRegAddr_q <= wregAddr(fieldWord[3:0], workingBankPointer);
                        fieldEscaped_q <= 1'b1;
                    end
                    `COD_KIND_WREG_IND: begin
                        // The caller reads the named register and returns its contents on fieldBase.
                        fieldRegAddr_q <= wregAddr(fieldWord[3:0], workingBankPointer);
                        fieldAddr_q    <= fieldBase;
                        fieldEscaped_q <= 1'b1;
                    end
                    `COD_KIND_REG_IND: begin
                        fieldRegAddr_q <= fldRegAddr;
                        fieldAddr_q    <= fieldBase;
                        fieldEscaped_q <= fldEsc;
                    end
                    `COD_KIND_WPAIR, `COD_KIND_WPAIR_IND: begin
                        // An odd index is flagged; the pair is rounded down to the even index and the one above it.
                        fieldRegAddr_q <= wregAddr({fieldWord[3:1], 1'b0}, workingBankPointer);
                        fieldIllegal_q <= fieldWord[0];
                        fieldEscaped_q <= 1'b1;
                        if (fieldKind == `COD_KIND_WPAIR_IND) begin
                            fieldAddr_q <= fieldBase;
                        end
                    end
                    `COD_KIND_RPAIR, `COD_KIND_RPAIR_IND: begin
                        fieldRegAddr_q <= {fldRegAddr[11:1], 1'b0};
                        fieldIllegal_q <= fieldWord[0];
                        fieldEscaped_q <= fldEsc;
                        if (fieldKind == `COD_KIND_RPAIR_IND) begin
                            fieldAddr_q <= fieldBase;
                        end
                    end
                    `COD_KIND_REL: begin
                        // fieldBase carries the address of the following instruction.
                        fieldAddr_q <= fieldBase + signExt8(fieldWord[7:0]);
                    end
                    `COD_KIND_INDEXED: begin
                        // fieldBase carries the contents of the indexed register or pair.
                        fieldAddr_q <= fieldBase + signExt8(fieldWord[7:0]);
                    end
                    default: begin
                        fieldData_q <= fieldWord[7:0];
                    end
                endcase
            end
        end
    end

endmodule

// ### cod_checker_properties.sv
// Checker: concurrent properties on the operand decoder ports.
`timescale 1ns/100ps
`include "cod_map.vh"

module cod_checker_properties (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [7:0]  workingBankPointer,
    input wire logic [7:0]  rdSrcData,
    input wire logic [7:0]  rdDstData,
    input wire logic        rdEn_q,
    input wire logic [11:0] rdDstAddr_q,
    input wire logic        wrEn_q,
    input wire logic [11:0] wrAddr_q,
    input wire logic [7:0]  wrData_q,
    input wire logic        fieldReq,
    input wire logic [3:0]  fieldKind,
    input wire logic [15:0] fieldWord,
    input wire logic [15:0] fieldBase,
    input wire logic        fieldDone_q,
    input wire logic [15:0] fieldAddr_q,
    input wire logic [11:0] fieldRegAddr_q,
    input wire logic [7:0]  fieldData_q,
    input wire logic [2:0]  fieldBit_q,
    input wire logic        fieldPol_q,
    input wire logic        fieldEscaped_q,
    input wire logic        fieldIllegal_q
);
    logic [3:0]  kindQ;
    logic [15:0] wordQ;
    logic [15:0] baseQ;
    logic [7:0]  ptrQ;
    wire  [11:0] workAddr = {ptrQ[3:0], ptrQ[7:4], wordQ[3:0]};
    wire         escHit   = wordQ[7:4] == `COD_ESC_NIBBLE;
    wire         done     = fieldDone_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Keep each request for one cycle, so an answer is judged against its own cause.
    always @(posedge clk) begin
        kindQ <= fieldKind;
        wordQ <= fieldWord;
        baseQ <= fieldBase;
        ptrQ  <= workingBankPointer;
    end

    AST_DONE: assert property (done == $past(fieldReq))
        else $error("field answer missing");
    AST_BIT: assert property (done && kindQ == `COD_KIND_BIT |-> fieldBit_q == wordQ[2:0])
        else $error("bit index wrong");
    AST_POL: assert property (done && kindQ == `COD_KIND_POL |-> fieldPol_q == wordQ[0])
        else $error("polarity wrong");
    AST_DIRECT: assert property (done && kindQ == `COD_KIND_DIRECT |-> fieldAddr_q == wordQ)
        else $error("direct address wrong");
    AST_EXT: assert property (done && kindQ == `COD_KIND_EXT_REG |-> fieldRegAddr_q == wordQ[11:0])
        else $error("extended address wrong");
    AST_IMM: assert property (done && kindQ inside {`COD_KIND_IMM, `COD_KIND_VECTOR} |-> fieldData_q == wordQ[7:0])
        else $error("data byte wrong");
    AST_REL: assert property (done && kindQ inside {`COD_KIND_REL, `COD_KIND_INDEXED}
        |-> fieldAddr_q == baseQ + {{8{wordQ[7]}}, wordQ[7:0]})
        else $error("offset address wrong");
    AST_WIND: assert property (done && kindQ == `COD_KIND_WREG_IND |-> fieldAddr_q == baseQ && fieldRegAddr_q == workAddr)
        else $error("indirect working address wrong");
    AST_REG: assert property (done && kindQ == `COD_KIND_REG
        |-> fieldEscaped_q == escHit && fieldRegAddr_q == (escHit ? workAddr : {4'h0, wordQ[7:0]}))
        else $error("register field wrong");
    AST_WPAIR: assert property (done && kindQ == `COD_KIND_WPAIR |-> fieldIllegal_q == wordQ[0] && fieldRegAddr_q == {workAddr[11:1], 1'b0})
        else $error("working pair wrong");
    AST_RPAIR: assert property (done && kindQ == `COD_KIND_RPAIR |-> fieldIllegal_q == wordQ[0] && !fieldRegAddr_q[0])
        else $error("register pair wrong");
    AST_WRITE: assert property ($rose(rdEn_q) |-> ##2 wrEn_q && wrAddr_q == $past(rdDstAddr_q, 2))
        else $error("write back missing");
    AST_SUM: assert property (wrEn_q |-> wrData_q == 8'($past(rdSrcData) + $past(rdDstData)))
        else $error("sum wrong");
endmodule

// ### cod_regfile_model.sv
// Register file model answering the decoder's addition reads and writes.
`timescale 1ns/100ps

module cod_regfile_model (
    input  wire logic        clk,
    input  wire logic        rdEn,
    input  wire logic [11:0] srcAddr,
    input  wire logic [11:0] dstAddr,
    input  wire logic        wrEn,
    input  wire logic [11:0] wrAddr,
    input  wire logic [7:0]  wrData,
    output logic      [7:0]  srcData,
    output logic      [7:0]  dstData
);
    logic [7:0] mem [0:4095];

    // Each location holds a pattern of its address, so a wrong address gives a wrong sum.
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ {i[11:8], 4'h5};
        end
    end

    // Data is valid only in the cycle after the strobe; else the lines toggle so stale data never passes.
    always @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        if (rdEn) begin
            srcData <= mem[srcAddr];
            dstData <= mem[dstAddr];
        end else begin
            srcData <= ~srcData;
            dstData <= ~dstData;
        end
    end
endmodule

// ### cod_operand_decoder_test.sv
// Testbench for the operand decoder with a register file model.
`timescale 1ns/100ps
`include "cod_map.vh"

module cod_operand_decoder_test;
    logic        clk, rstn, byteValid, instrStart, fieldReq;
    logic [7:0]  byteData, workingBankPointer;
    logic [3:0]  fieldKind;
    logic [15:0] fieldWord, fieldBase;
    wire  [7:0]  rdSrcData, rdDstData, wrData_q, fieldData_q;
    wire         addBusy_q, rdEn_q, srcEscaped_q, dstEscaped_q, wrEn_q;
    wire         fieldDone_q, fieldPol_q, fieldEscaped_q, fieldIllegal_q;
    wire  [11:0] rdSrcAddr_q, rdDstAddr_q, wrAddr_q, fieldRegAddr_q;
    wire  [15:0] fieldAddr_q;
    wire  [2:0]  fieldBit_q;
    int          n_errors, n_checks;

    cod_operand_decoder i_dut (.clk(clk), .rstn(rstn), .byteValid(byteValid), .instrStart(instrStart),
        .byteData(byteData), .workingBankPointer(workingBankPointer), .rdSrcData(rdSrcData),
        .rdDstData(rdDstData), .addBusy_q(addBusy_q), .rdEn_q(rdEn_q), .rdSrcAddr_q(rdSrcAddr_q),
        .rdDstAddr_q(rdDstAddr_q), .srcEscaped_q(srcEscaped_q), .dstEscaped_q(dstEscaped_q),
        .wrEn_q(wrEn_q), .wrAddr_q(wrAddr_q), .wrData_q(wrData_q), .fieldReq(fieldReq),
        .fieldKind(fieldKind), .fieldWord(fieldWord), .fieldBase(fieldBase), .fieldDone_q(fieldDone_q),
        .fieldAddr_q(fieldAddr_q), .fieldRegAddr_q(fieldRegAddr_q), .fieldData_q(fieldData_q),
        .fieldBit_q(fieldBit_q), .fieldPol_q(fieldPol_q), .fieldEscaped_q(fieldEscaped_q),
        .fieldIllegal_q(fieldIllegal_q));

    cod_regfile_model i_regfile (.clk(clk), .rdEn(rdEn_q), .srcAddr(rdSrcAddr_q), .dstAddr(rdDstAddr_q),
        .wrEn(wrEn_q), .wrAddr(wrAddr_q), .wrData(wrData_q), .srcData(rdSrcData), .dstData(rdDstData));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic close_out;
        $display("Checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic [11:0] resolve(input logic [7:0] f, input logic [7:0] p);
        return (f[7:4] == 4'he) ? {p[3:0], p[7:4], f[3:0]} : {4'h0, f};
    endfunction

    function automatic logic [7:0] seedOf(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction

    task automatic sendByte(input logic start, input logic [7:0] d);
        @(posedge clk);
        #1;
        byteValid = 1'b1;
        instrStart = start;
        byteData = d;
    endtask

    // Full addition; the write-back latency is fixed, so the wait count is checked too.
    task automatic scen_add(input logic [7:0] src, input logic [7:0] dst, input logic [7:0] ptr);
        int n;
        workingBankPointer = ptr;
        sendByte(1'b1, `COD_OPC_ADD_RR);
        sendByte(1'b0, src);
        check("busyHigh", addBusy_q, 1'b1);
        sendByte(1'b0, dst);
        @(posedge clk);
        #1;
        byteValid = 1'b0;
        for (n = 0; n < 9 && wrEn_q !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 9) begin
            n_errors++;
            close_out;
        end
        check("wrLatency", 16'(n), 16'h0002);
        check("busyDone", addBusy_q, 1'b0);
        check("rdSrcAddr", rdSrcAddr_q, resolve(src, ptr));
        check("rdDstAddr", rdDstAddr_q, resolve(dst, ptr));
        check("srcEscaped", srcEscaped_q, src[7:4] == 4'he);
        check("dstEscaped", dstEscaped_q, dst[7:4] == 4'he);
        check("wrAddr", wrAddr_q, resolve(dst, ptr));
        // The sum wraps in eight bits; without the cast the carry would leak into the 16-bit compare.
        check("wrData", wrData_q, 8'(seedOf(resolve(dst, ptr)) + seedOf(resolve(src, ptr))));
    endtask

    // An opcode byte during operand collection aborts; another opcode must not start the sequence.
    task automatic scen_other_opcode;
        sendByte(1'b1, `COD_OPC_ADD_RR);
        sendByte(1'b0, 8'h08);
        sendByte(1'b1, 8'h05);
        sendByte(1'b0, 8'h08);
        sendByte(1'b0, 8'h43);
        repeat (4) begin
            @(posedge clk);
            #1;
            byteValid = 1'b0;
            check("addIdle", {addBusy_q, rdEn_q, wrEn_q}, 3'h0);
        end
    endtask

    task automatic field(input logic [3:0] k, input logic [15:0] w, input logic [15:0] b);
        fieldReq = 1'b1;
        fieldKind = k;
        fieldWord = w;
        fieldBase = b;
        @(posedge clk);
        #1;
        // The request stays up between calls, so back-to-back decodes are exercised.
        check("fieldDone", fieldDone_q, 1'b1);
    endtask

    // Every kind at both ends of its field, then the awkward cases by hand.
    task automatic scen_fields;
        workingBankPointer = 8'h21;
        for (int k = 0; k < 16; k++) begin
            field(k[3:0], 16'h0000, 16'h1000);
            field(k[3:0], 16'hffff, 16'h1000);
        end
        field(`COD_KIND_POL, 16'hfffe, 16'h0000);
        check("pol", fieldPol_q, 1'b0);
        field(`COD_KIND_DIRECT, 16'hfffe, 16'h0000);
        check("direct", fieldAddr_q, 16'hfffe);
        field(`COD_KIND_EXT_REG, 16'h0fff, 16'h0000);
        check("extReg", fieldRegAddr_q, 12'hfff);
        field(`COD_KIND_IMM, 16'h00a5, 16'h0000);
        check("imm", fieldData_q, 8'ha5);
        field(`COD_KIND_VECTOR, 16'h005a, 16'h0000);
        check("vector", fieldData_q, 8'h5a);
        field(`COD_KIND_BIT, 16'h0007, 16'h0000);
        check("bit", fieldBit_q, 3'h7);
        field(`COD_KIND_REL, 16'h0080, 16'h1000);
        check("relBack", fieldAddr_q, 16'h0f80);
        field(`COD_KIND_REL, 16'h007f, 16'hfff0);
        check("relWrap", fieldAddr_q, 16'h006f);
        field(`COD_KIND_INDEXED, 16'h00ff, 16'h0200);
        check("indexed", fieldAddr_q, 16'h01ff);
        field(`COD_KIND_WREG_IND, 16'h000f, 16'h4321);
        check("wregInd", fieldRegAddr_q, 12'h12f);
        field(`COD_KIND_WPAIR, 16'h0003, 16'h0000);
        check("oddPair", {fieldIllegal_q, fieldRegAddr_q}, 13'h1122);
        field(`COD_KIND_RPAIR, 16'h00fe, 16'h0000);
        check("regPair", {fieldIllegal_q, fieldRegAddr_q}, 13'h00fe);
        field(`COD_KIND_REG, 16'h00e8, 16'h0000);
        check("regEsc", {fieldEscaped_q, fieldRegAddr_q}, 13'h1128);
        field(`COD_KIND_REG, 16'h00d8, 16'h0000);
        check("regAbs", {fieldEscaped_q, fieldRegAddr_q}, 13'h00d8);
        fieldReq = 1'b0;
    endtask

    // Free-running clock at 50 ns.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Main sequence: reset, additions, refusal, field decodes.
    initial begin
        rstn = 1'b0;
        {byteValid, instrStart, fieldReq} = 3'h0;
        byteData = 8'h00;
        workingBankPointer = 8'h00;
        fieldKind = 4'h0;
        fieldWord = 16'h0000;
        fieldBase = 16'h0000;
        n_errors = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        #1;
        rstn = 1'b1;
        check("idle", {addBusy_q, rdEn_q, wrEn_q, fieldDone_q}, 4'h0);
        scen_add(8'h08, 8'h43, 8'h00);
        scen_add(8'he8, 8'h44, 8'h21);
        scen_add(8'hff, 8'hef, 8'h7c);
        scen_other_opcode;
        scen_fields;
        close_out;
    end
endmodule

bind cod_operand_decoder cod_checker_properties i_chk (.clk(clk), .rstn(rstn),
    .workingBankPointer(workingBankPointer), .rdSrcData(rdSrcData), .rdDstData(rdDstData),
    .rdEn_q(rdEn_q), .rdDstAddr_q(rdDstAddr_q), .wrEn_q(wrEn_q), .wrAddr_q(wrAddr_q),
    .wrData_q(wrData_q), .fieldReq(fieldReq), .fieldKind(fieldKind), .fieldWord(fieldWord),
    .fieldBase(fieldBase), .fieldDone_q(fieldDone_q), .fieldAddr_q(fieldAddr_q),
    .fieldRegAddr_q(fieldRegAddr_q), .fieldData_q(fieldData_q), .fieldBit_q(fieldBit_q),
    .fieldPol_q(fieldPol_q), .fieldEscaped_q(fieldEscaped_q), .fieldIllegal_q(fieldIllegal_q));
